// >>> rtl/power_managed_mode_control.sv
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "pm_consts.svh"

// Function
// - Sleep with idle select clear: stop primary and fast oscillators, clear all clock flags.
// - Slow oscillator runs with watchdog on; secondary runs whenever enabled.
// - Sleep wake withholds clocks until source ready, or runs internal if fast start and primary selected.
// - After sleep wake set primary flag once primary drives; control bits untouched.
// - Idle sleep stops CPU clock, peripherals stay clocked, flags unchanged unless the idle source differs.
// - Idle left only by interrupt, watchdog or reset; resume on same source.
// - Watchdog time-out in sleep or idle wakes into selected run mode.
// - Primary idle keeps peripherals on primary and primary flag set.
// - Primary idle wake clocks CPU from primary after delay, flag stays set.
// - Secondary idle stops primary, clears primary flag, sets secondary flag.
// - Secondary idle with secondary disabled: sleep ignored, mode kept.
// - Secondary idle wake: stays on secondary, CPU runs after delay.
// - Upper select bit picks internal idle; lower bit ignored; primary stopped.
// - Fast oscillator on when frequency nonzero or source bit; flag after settling.
// - Already stable flag stays set; all zero keeps oscillator off, flag clear, unless cfg_primary_internal is set.
// - Internal idle wake stays on internal; slow oscillator kept for watchdog.
// - Enabled interrupt wakes; vector branch only with global enable set.
// - Every wake waits the CPU-ready delay before execution resumes.
// - Watchdog time-out while executing gives watchdog reset.
// - Watchdog cleared on sleep, clear op, clock loss, internal frequency write.
// - Reset exit holds for start-up timer, then sets ready flag and runs.
// - Fast start runs on internal at once until primary ready or sleep.
// - Clock switch takes two old plus four new cycles, longer if the new source is not yet ready.

module power_managed_mode_control
#(
   parameter int unsigned CSD_CYCLES   = `CSD_CYCLES,
   parameter int unsigned IOBST_CYCLES = `IOBST_CYCLES,
   parameter int unsigned OST_CYCLES   = `OST_CYCLES
)
(
   // Clock and reset
   input  logic        clk_sys,
   input  logic        rst,
   // Register bus
   input  logic [3:0]  address,
   input  logic        read,
   input  logic        write,
   input  logic [31:0] writedata,
   input  logic [3:0]  byteenable,
   output logic [31:0] readdata,
   output logic        waitrequest,
   // Configuration straps
   input  logic        cfg_two_speed,
   input  logic        cfg_failsafe,
   input  logic        cfg_watchdog_on,
   input  logic        cfg_primary_internal,
   // CPU core
   input  logic        sleep_op,
   input  logic        watchdog_clear_op,
   input  logic        irq_pending,
   input  logic        watchdog_timeout,
   output logic        cpu_clk_en,
   output logic        periph_clk_en,
   output logic        cpu_hold_reset,
   output logic        irq_vector_branch,
   output logic        watchdog_reset,
   output logic        watchdog_counter_clear,
   // Oscillators
   input  logic        primary_osc_ready,
   input  logic        secondary_osc_ready,
   input  logic        clock_fail,
   output logic        primary_osc_en,
   output logic        secondary_osc_en,
   output logic        fast_osc_en,
   output logic        slow_osc_en,
   output logic [1:0]  clk_src_sel,
   // Status flags
   output logic        primary_clock_ready_flag,
   output logic        internal_osc_stable_flag,
   output logic        secondary_osc_running_flag
);

   localparam logic [15:0] CTRL_MASK = `CTRL_MASK;

   pm_pkg::pm_state_e state;
   pm_pkg::clk_src_e  run_src;
   pm_pkg::clk_src_e  tgt_src;
   pm_pkg::clk_src_e  sel_src;
   logic [15:0]       ctrl;
   logic [31:0]       rd_word;
   logic [2:0]        pin_s;
   logic              idle_req;
   logic              from_sleep;
   logic              wake_irq;
   logic              pend_primary;
   logic              pri_rdy;
   logic              sec_rdy;
   logic              clk_fail_s;
   logic              ost_done;
   logic              csd_done;
   logic              iob_done;
   logic              sw_done;
   logic              fast_start;
   logic              wake_ev;
   logic              cpu_exec;
   logic              live;
   logic              tgt_ready;
   logic              bus_wr;
   logic              ifs_change;
   logic              fast_want;
   logic              use_int;
   logic              need_pri;

   function automatic pm_pkg::clk_src_e decode_src(input logic [1:0] cs);
      if (cs[1])
         decode_src = pm_pkg::src_internal;
      else if (cs[0])
         decode_src = pm_pkg::src_secondary;
      else
         decode_src = pm_pkg::src_primary;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and timers

   pin_sync #(.W(`SYNC_W)) u_sync
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin_in  ({primary_osc_ready, secondary_osc_ready, clock_fail}),
      .pin_out (pin_s)
   );

   assign {pri_rdy, sec_rdy, clk_fail_s} = pin_s;

   // Start-up hold counted from primary oscillator ready
   delay_timer #(.LEN(OST_CYCLES)) u_ost
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (primary_osc_en && pri_rdy),
      .done    (ost_done)
   );

   delay_timer #(.LEN(CSD_CYCLES)) u_csd
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (state == pm_pkg::st_wake),
      .done    (csd_done)
   );

   delay_timer #(.LEN(IOBST_CYCLES)) u_iob
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (fast_osc_en),
      .done    (iob_done)
   );

   delay_timer #(.LEN(`SW_CYCLES)) u_sw
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (state == pm_pkg::st_switch),
      .done    (sw_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   assign sel_src    = decode_src(ctrl[`CTRL_CS]);
   assign fast_start = cfg_two_speed || cfg_failsafe;
   assign wake_ev    = irq_pending || watchdog_timeout;
   assign cpu_exec   = (state == pm_pkg::st_run) || (state == pm_pkg::st_switch && !idle_req);
   assign live       = (state inside {pm_pkg::st_run, pm_pkg::st_switch, pm_pkg::st_idle})
                       || (state == pm_pkg::st_wake && !from_sleep);
   assign bus_wr     = write && !waitrequest;
   assign ifs_change = bus_wr && address == `REG_CTRL && byteenable[0]
                       && writedata[`CTRL_IFS] != ctrl[`CTRL_IFS];
   assign fast_want  = ctrl[`CTRL_IFS] != 3'h0 || ctrl[`CTRL_ISRC] || cfg_primary_internal;
   assign use_int    = (live && run_src == pm_pkg::src_internal)
                       || (state inside {pm_pkg::st_switch, pm_pkg::st_wake} && tgt_src == pm_pkg::src_internal)
                       || (state == pm_pkg::st_hold && cfg_primary_internal);
   assign need_pri   = pend_primary
                       || (state == pm_pkg::st_hold && !cfg_primary_internal)
                       || (live && run_src == pm_pkg::src_primary)
                       || (state inside {pm_pkg::st_switch, pm_pkg::st_wake} && tgt_src == pm_pkg::src_primary);

   always_comb
   begin
      case (tgt_src)
         pm_pkg::src_primary:   tgt_ready = ost_done;
         pm_pkg::src_secondary: tgt_ready = sec_rdy;
         default:               tgt_ready = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register bus

   // One wait cycle per request
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         waitrequest <= 1'b1;
      else
         waitrequest <= !((read || write) && waitrequest);
   end

   always_comb
   begin
      case (address)
         `REG_CTRL:   rd_word = {16'h0000, ctrl};
         `REG_STATUS: rd_word = {16'h0000, 2'h0, run_src, 1'h0, state, 2'h0, cpu_hold_reset,
                                 periph_clk_en, cpu_clk_en, secondary_osc_running_flag,
                                 internal_osc_stable_flag, primary_clock_ready_flag};
         default:     rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         readdata <= 32'h0000_0000;
      else if (read && waitrequest)
         readdata <= rd_word;
   end

   // Hardware never alters the control bits
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ctrl <= `CTRL_RESET;
      else if (bus_wr && address == `REG_CTRL)
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (byteenable[b])
               ctrl[b*8 +: 8] <= writedata[b*8 +: 8] & CTRL_MASK[b*8 +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequencer

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state        <= pm_pkg::st_hold;
         run_src      <= pm_pkg::src_primary;
         tgt_src      <= pm_pkg::src_primary;
         idle_req     <= 1'b0;
         from_sleep   <= 1'b0;
         wake_irq     <= 1'b0;
         pend_primary <= 1'b0;
      end
      else
      begin
         case (state)
            pm_pkg::st_hold:
            begin
               if (fast_start)
               begin
                  state        <= pm_pkg::st_run;
                  run_src      <= pm_pkg::src_internal;
                  pend_primary <= !cfg_primary_internal;
               end
               else if (cfg_primary_internal)
               begin
                  if (iob_done)
                  begin
                     state   <= pm_pkg::st_run;
                     run_src <= pm_pkg::src_internal;
                  end
               end
               else if (ost_done)
               begin
                  state   <= pm_pkg::st_run;
                  run_src <= pm_pkg::src_primary;
               end
            end
            pm_pkg::st_run:
            begin
               if (sleep_op)
               begin
                  if (!ctrl[`CTRL_IDLE])
                  begin
                     state        <= pm_pkg::st_sleep;
                     from_sleep   <= 1'b1;
                     pend_primary <= 1'b0;
                  end
                  else if (sel_src == pm_pkg::src_secondary && !ctrl[`CTRL_SEC_EN])
                     state <= pm_pkg::st_run;
                  else
                  begin
                     tgt_src      <= sel_src;
                     idle_req     <= 1'b1;
                     pend_primary <= 1'b0;
                     state        <= (sel_src == run_src) ? pm_pkg::st_idle : pm_pkg::st_switch;
                  end
               end
               else if (pend_primary && ost_done)
               begin
                  tgt_src      <= pm_pkg::src_primary;
                  idle_req     <= 1'b0;
                  pend_primary <= 1'b0;
                  state        <= pm_pkg::st_switch;
               end
            end
            pm_pkg::st_switch:
            begin
               if (sw_done && tgt_ready)
               begin
                  run_src <= tgt_src;
                  state   <= idle_req ? pm_pkg::st_idle : pm_pkg::st_run;
               end
            end
            pm_pkg::st_sleep:
            begin
               if (wake_ev)
               begin
                  state        <= pm_pkg::st_wake;
                  wake_irq     <= irq_pending;
                  tgt_src      <= (fast_start && sel_src == pm_pkg::src_primary) ? pm_pkg::src_internal : sel_src;
                  pend_primary <= fast_start && sel_src == pm_pkg::src_primary;
               end
            end
            pm_pkg::st_idle:
            begin
               if (wake_ev)
               begin
                  state    <= pm_pkg::st_wake;
                  wake_irq <= irq_pending;
                  tgt_src  <= run_src;
               end
            end
            pm_pkg::st_wake:
            begin
               if (csd_done && tgt_ready)
               begin
                  state      <= pm_pkg::st_run;
                  run_src    <= tgt_src;
                  from_sleep <= 1'b0;
                  idle_req   <= 1'b0;
               end
            end
            default:
               state <= pm_pkg::st_hold;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock gates and oscillator enables

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cpu_clk_en     <= 1'b0;
         periph_clk_en  <= 1'b0;
         cpu_hold_reset <= 1'b1;
         clk_src_sel    <= 2'h0;
      end
      else
      begin
         cpu_clk_en     <= cpu_exec;
         periph_clk_en  <= (state inside {pm_pkg::st_run, pm_pkg::st_switch, pm_pkg::st_idle})
                           || (state == pm_pkg::st_wake && tgt_ready);
         cpu_hold_reset <= state == pm_pkg::st_hold;
         clk_src_sel    <= (state == pm_pkg::st_wake) ? tgt_src : run_src;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         primary_osc_en   <= 1'b0;
         fast_osc_en      <= 1'b0;
         slow_osc_en      <= 1'b0;
         secondary_osc_en <= 1'b0;
      end
      else
      begin
         primary_osc_en   <= need_pri;
         fast_osc_en      <= use_int && fast_want;
         slow_osc_en      <= cfg_watchdog_on || cfg_failsafe || (use_int && !fast_want);
         secondary_osc_en <= ctrl[`CTRL_SEC_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags and events

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         primary_clock_ready_flag   <= 1'b0;
         secondary_osc_running_flag <= 1'b0;
         internal_osc_stable_flag   <= 1'b0;
      end
      else
      begin
         primary_clock_ready_flag   <= live && run_src == pm_pkg::src_primary;
         secondary_osc_running_flag <= live && run_src == pm_pkg::src_secondary;
         internal_osc_stable_flag   <= fast_osc_en && iob_done;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         watchdog_reset         <= 1'b0;
         watchdog_counter_clear <= 1'b0;
         irq_vector_branch      <= 1'b0;
      end
      else
      begin
         watchdog_reset         <= cpu_exec && watchdog_timeout;
         watchdog_counter_clear <= (cpu_exec && sleep_op) || watchdog_clear_op || (cfg_failsafe && clk_fail_s)
                                   || (ifs_change && live && run_src == pm_pkg::src_internal);
         irq_vector_branch      <= state == pm_pkg::st_wake && csd_done && tgt_ready
                                   && wake_irq && ctrl[`CTRL_GIE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_sleep_entry;
      state == pm_pkg::st_run && sleep_op && !ctrl[`CTRL_IDLE] |=> state == pm_pkg::st_sleep
         ##1 (!primary_clock_ready_flag && !secondary_osc_running_flag && !internal_osc_stable_flag && !cpu_clk_en);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

   property p_sec_ignored;
      state == pm_pkg::st_run && sleep_op && ctrl[`CTRL_IDLE] && ctrl[`CTRL_CS] == `CTRL_CS_SEC
         && !ctrl[`CTRL_SEC_EN] |=> state == pm_pkg::st_run;
   endproperty
   a_sec_ignored: assert property (p_sec_ignored) else $error("sleep not ignored");

   property p_secondary_idle;
      state == pm_pkg::st_run && run_src == pm_pkg::src_primary && sleep_op && ctrl[`CTRL_IDLE]
         && ctrl[`CTRL_CS] == `CTRL_CS_SEC && ctrl[`CTRL_SEC_EN] && sec_rdy
         |=> ##[1:20] (secondary_osc_running_flag && !primary_clock_ready_flag && !primary_osc_en);
   endproperty
   a_secondary_idle: assert property (p_secondary_idle) else $error("secondary idle flags wrong");

   property p_wdt_reset;
      state == pm_pkg::st_run && watchdog_timeout |=> watchdog_reset;
   endproperty
   a_wdt_reset: assert property (p_wdt_reset) else $error("no watchdog reset");

   property p_wdt_wake;
      state inside {pm_pkg::st_sleep, pm_pkg::st_idle} && watchdog_timeout
         |=> state == pm_pkg::st_wake && !watchdog_reset;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog did not wake");

   property p_wdt_clear;
      watchdog_clear_op |=> watchdog_counter_clear;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

   property p_idle_gates;
      state == pm_pkg::st_idle && $past(state) == pm_pkg::st_idle |-> periph_clk_en && !cpu_clk_en;
   endproperty
   a_idle_gates: assert property (p_idle_gates) else $error("idle gating wrong");

   property p_wake_delay;
      state == pm_pkg::st_idle && irq_pending |=> (!cpu_clk_en) [*8] ##[1:1000] cpu_clk_en;
   endproperty
   a_wake_delay: assert property (p_wake_delay) else $error("wake delay wrong");

   property p_sleep_withhold;
      state == pm_pkg::st_wake && from_sleep && tgt_src == pm_pkg::src_primary && !ost_done |=> !periph_clk_en;
   endproperty
   a_sleep_withhold: assert property (p_sleep_withhold) else $error("clock not withheld");

   property p_fast_off;
      !fast_osc_en |=> !internal_osc_stable_flag;
   endproperty
   a_fast_off: assert property (p_fast_off) else $error("stable flag without oscillator");

   property p_branch_gie;
      irq_vector_branch |-> $past(ctrl[`CTRL_GIE]) && $past(wake_irq);
   endproperty
   a_branch_gie: assert property (p_branch_gie) else $error("branch without enable");

   c_sleep: cover property (state == pm_pkg::st_sleep ##1 state == pm_pkg::st_wake);
   c_idle: cover property (state == pm_pkg::st_idle ##1 state == pm_pkg::st_wake);
   c_wdt_reset: cover property (watchdog_reset);
   c_branch: cover property (irq_vector_branch);

endmodule

// >>> rtl/pm_consts.svh
`ifndef PM_CONSTS_SVH
`define PM_CONSTS_SVH

// Clock rate
`define CLK_PERIOD_NS   10

// CPU-ready delay after a wake event
`define CSD_TIME_NS     2000
`define CSD_CYCLES      ((`CSD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Fast internal oscillator settling interval
`define IOBST_TIME_NS   1000
`define IOBST_CYCLES    ((`IOBST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Oscillator start-up hold, in oscillator periods
`define OST_PERIODS     1024
`define OST_CYCLES      `OST_PERIODS

// Clock switch: old source cycles plus new source cycles
`define SW_OLD_CYCLES   2
`define SW_NEW_CYCLES   4
`define SW_CYCLES       (`SW_OLD_CYCLES + `SW_NEW_CYCLES)

// Widths
`define TIMER_W         16
`define SYNC_W          3

// Register offsets (byte addresses)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4

// Control register fields
`define CTRL_IDLE       0
`define CTRL_CS         2:1
`define CTRL_CS_SEC     2'h1
`define CTRL_IFS        6:4
`define CTRL_ISRC       7
`define CTRL_SEC_EN     8
`define CTRL_GIE        9
`define CTRL_RESET      16'h0000
`define CTRL_MASK       16'h03F7

`endif

// >>> rtl/pm_pkg.sv
package pm_pkg;

   typedef enum logic [2:0] {
      st_hold,
      st_run,
      st_switch,
      st_sleep,
      st_idle,
      st_wake
   } pm_state_e;

   typedef enum logic [1:0] {
      src_primary,
      src_secondary,
      src_internal
   } clk_src_e;

endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
`include "pm_consts.svh"

module pin_sync
#(
   parameter int W = `SYNC_W
)
(
   // Clock and reset
   input  logic         clk_sys,
   input  logic         rst,
   // Pins
   input  logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else
      begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Change taken once stages two and three agree
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk_sys or posedge rst)
      begin
         if (rst)
            pin_out[i] <= 1'b0;
         else if (s2[i] == s3[i])
            pin_out[i] <= s3[i];
      end
   end

endmodule

// >>> rtl/delay_timer.sv
`timescale 1ns/1ps
`include "pm_consts.svh"

module delay_timer
#(
   parameter int unsigned LEN = 1
)
(
   // Clock and reset
   input  logic clk_sys,
   input  logic rst,
   // Timing
   input  logic run,
   output logic done
);

   logic [`TIMER_W-1:0] count;

   // Counts while run stays high; done holds until run drops
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         count <= `TIMER_W'(0);
         done  <= 1'b0;
      end
      else if (!run)
      begin
         count <= `TIMER_W'(0);
         done  <= 1'b0;
      end
      else if (count == `TIMER_W'(LEN - 1))
         done <= 1'b1;
      else
         count <= count + `TIMER_W'(1);
   end

endmodule

// >>> sim/osc_model.sv
`timescale 1ns/1ps

module osc_model
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Oscillators
   input  wire logic primary_osc_en,
   input  wire logic secondary_osc_en,
   output wire logic primary_osc_ready,
   output wire logic secondary_osc_ready
);
   logic [1:0] pcnt;
   logic [1:0] scnt;

   // Ready three cycles after enable, low once shut
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         pcnt <= 2'h0;
      else
         pcnt <= !primary_osc_en ? 2'h0 : pcnt + {1'h0, pcnt != 2'h3};
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         scnt <= 2'h0;
      else
         scnt <= !secondary_osc_en ? 2'h0 : scnt + {1'h0, scnt != 2'h3};
   assign primary_osc_ready   = pcnt == 2'h3;
   assign secondary_osc_ready = scnt == 2'h3;
endmodule

// >>> sim/tb_power_managed_mode_control.sv
`timescale 1ns/1ps

module tb_power_managed_mode_control;
   logic clk_sys = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, irq = 1'h0;
   logic clr = 1'h0, wdog = 1'h0, cf = 1'h0, iflag, fen, slo;
   logic [1:0] csel;
   logic [3:0] address = 4'h0, byteenable = 4'h3;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic [2:0] ev = 3'h0, seen = 3'h0;
   logic waitrequest, cpu_clk_en, periph_clk_en, cpu_hold_reset, vec, wrst, wclr;
   logic pen, sen, pry, sry, pflag, sflag;
   int errors = 0, checks = 0, cycles = 0;

   always #5 clk_sys = ~clk_sys;

   power_managed_mode_control #(.CSD_CYCLES(10), .IOBST_CYCLES(4), .OST_CYCLES(8)) u_power_managed_mode_control
   (
      .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .cfg_two_speed(1'h0), .cfg_failsafe(1'h0), .cfg_watchdog_on(wdog), .cfg_primary_internal(1'h0),
      .sleep_op(ev[0]), .watchdog_clear_op(ev[2]), .irq_pending(irq), .watchdog_timeout(ev[1]),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .cpu_hold_reset(cpu_hold_reset),
      .irq_vector_branch(vec), .watchdog_reset(wrst), .watchdog_counter_clear(wclr),
      .primary_osc_ready(pry), .secondary_osc_ready(sry), .clock_fail(cf),
      .primary_osc_en(pen), .secondary_osc_en(sen), .fast_osc_en(fen), .slow_osc_en(slo), .clk_src_sel(csel),
      .primary_clock_ready_flag(pflag), .internal_osc_stable_flag(iflag),
      .secondary_osc_running_flag(sflag)
   );

   osc_model u_osc_model
   (
      .clk_sys(clk_sys), .rst(rst), .primary_osc_en(pen), .secondary_osc_en(sen),
      .primary_osc_ready(pry), .secondary_osc_ready(sry)
   );

   // Catch one-cycle pulses
   always @(posedge clk_sys)
      seen <= clr ? 3'h0 : (seen | {wclr, vec, wrst});

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         errors++;
         tally_and_finish;
      end
   end

   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do @(posedge clk_sys); while (waitrequest !== 1'h0);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
   endtask

   task pulse(input int i);
      @(posedge clk_sys);
      clr <= 1'h1;
      ev[i] <= 1'h1;
      @(posedge clk_sys);
      clr <= 1'h0;
      ev[i] <= 1'h0;
      repeat (4) @(posedge clk_sys);
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      if (g !== e)
         errors++;
   endtask

   task wake;
      irq <= 1'h1;
      wait (cpu_clk_en === 1'h1);
      irq <= 1'h0;
      repeat (2) @(posedge clk_sys);
   endtask

   task tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'h0;
      wait (cpu_hold_reset === 1'h0);
      @(posedge clk_sys);
      chk(pflag, 1'h1);
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h0);
      bus(1'h0, 4'h8, 32'h0);
      chk(q, 32'h0);
      pulse(0);
      chk({cpu_clk_en, periph_clk_en, pflag, sflag, seen[2]}, 5'h01);
      wake;
      chk(pflag, 1'h1);
      bus(1'h1, 4'h0, 32'h1);
      pulse(0);
      chk({cpu_clk_en, periph_clk_en, pflag}, 3'h3);
      pulse(1);
      wait (cpu_clk_en === 1'h1);
      chk({seen[0], pflag}, 2'h1);
      bus(1'h1, 4'h0, 32'h3);
      pulse(0);
      chk(cpu_clk_en, 1'h1);
      pulse(1);
      chk(seen[0], 1'h1);
      pulse(2);
      chk(seen[2], 1'h1);
      bus(1'h1, 4'h0, 32'h303);
      repeat (10) @(posedge clk_sys);
      pulse(0);
      wait (sflag === 1'h1 && cpu_clk_en === 1'h0);
      chk(pflag, 1'h0);
      wake;
      chk({seen[1], sflag}, 2'h3);
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h303);
      bus(1'h1, 4'h0, 32'h315);
      wdog <= 1'h1;
      pulse(0);
      repeat (10) @(posedge clk_sys);
      chk({cpu_clk_en, periph_clk_en, pflag, sflag, iflag, fen, slo, csel}, 9'h09E);
      bus(1'h0, 4'h4, 32'h0);
      chk(q, 32'h2412);
      wake;
      chk({pflag, iflag, csel}, 4'h6);
      tally_and_finish;
   end
endmodule
